// ===== logic/pcs_pkg.sv
// package for the clock synthesizer control block
// assumes a single pclk domain and an apb register port
package pcs_pkg;

  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] PCS_ADDR_CTRL   = 8'h00;  // clock_synth_control
  localparam logic [7:0] PCS_ADDR_STATUS = 8'h04;  // sticky event status, write one to clear
  localparam logic [7:0] PCS_ADDR_MASK   = 8'h08;  // interrupt mask
  localparam logic [7:0] PCS_ADDR_STATE  = 8'h0C;  // live block state, read only

  // ---------------------------------------------------------------
  // control register fields and reset value
  // ---------------------------------------------------------------
  localparam logic [15:0] PCS_CTRL_RESET = 16'h3F00;
  localparam int PCS_BIT_FBQUAD   = 15;
  localparam int PCS_BIT_OUTPRE   = 14;
  localparam int PCS_Y_LSB        = 8;
  localparam int PCS_Y_W          = 6;
  localparam int PCS_BIT_DIVSEL   = 7;
  localparam int PCS_BIT_REFLOST  = 4;
  localparam int PCS_BIT_LOCK     = 3;
  localparam int PCS_BIT_LOSSRST  = 2;
  localparam int PCS_BIT_STOPSRC  = 1;
  localparam int PCS_BIT_STOPKEEP = 0;
  // bits software may write: fb quad, out prescale, modulus, div select, control bits
  localparam logic [15:0] PCS_CTRL_WMASK = 16'hFF87;

  // ---------------------------------------------------------------
  // event status bits
  // ---------------------------------------------------------------
  localparam int PCS_EV_W      = 3;
  localparam int PCS_EV_LOCK   = 0;  // lock achieved
  localparam int PCS_EV_UNLOCK = 1;  // lock lost
  localparam int PCS_EV_REFLOS = 2;  // reference lost

  // ---------------------------------------------------------------
  // timing and dividers
  // ---------------------------------------------------------------
  localparam int PCS_RELOCK_REF_CYCLES = 16;  // default relock wait in reference cycles
  localparam int PCS_SLOW_DIV_LO       = 8;
  localparam int PCS_SLOW_DIV_HI       = 16;
  localparam int PCS_FB_PRESCALE_LOG2  = 2;   // fb quad tap multiplies by 4
  localparam int PCS_BASE_MULT         = 4;

  // sequencing of lock
  typedef enum logic [1:0] {PCS_ST_RESET, PCS_ST_RELOCK, PCS_ST_LOCKED, PCS_ST_LIMP} pcs_state_e;

  // settings handed to the analog loop
  typedef struct packed {
    logic       fb_quad;
    logic       out_prescale;
    logic [5:0] modulus;
    logic       loop_enable;
  } pcs_loop_cfg_s;

endpackage : pcs_pkg

// ===== logic/pcs_clock_synth_ctrl.sv
// control and status logic for the phase-locked clock synthesizer
// assumes apb master on pclk, analog loop flags sampled on pclk
//
// Contract
// - hold chip reset until lock reported
// - output prescale doubles clock, no relock
// - fb quad selects prescaler tap, forces relock
// - six-bit modulus, feedback divides by Y+1
// - fsys = fref*4*(Y+1)*2^(2W+X)
// - vco runs 2x or 4x system clock
// - changing W or Y forces relock delay
// - control register resets to 3F00
// - control register only at supervisor level
// - slow bus clock divides by 8 or 16
// - reference loss sets flag, vco keeps running
// - crystal loss: limp or system reset
// - lock flag valid after first write
// - stop mode core clock source select
// - stop mode clock output held or driven
// - strap pin sampled during reset picks source; the code samples it at the first pclk edge after reset release
// - limp clock still scaled by prescale bit
// - external clock disables frequency bits; the code still passes modulus on loop_cfg and out prescale to vco_to_sys_ratio
//
// The register offsets and the APB register port were chosen for this implementation.
`timescale 1ns/100ps
module pcs_clock_synth_ctrl
  import pcs_pkg::*;
#(
  parameter int RELOCK_REF_CYCLES = PCS_RELOCK_REF_CYCLES
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  // apb slave
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [7:0]    paddr,
  input  wire logic [31:0]   pwdata,
  input  wire logic [2:0]    pprot,
  output logic               pready,
  output logic [31:0]        prdata,
  output logic               pslverr,
  // strap and analog loop
  input  wire logic          clock_source_strap,
  input  wire logic          loop_lock_in,
  input  wire logic          ref_present_in,
  input  wire logic          ref_clk_tick,
  output pcs_loop_cfg_s      loop_cfg,
  output logic [9:0]         vco_to_sys_ratio,
  output logic [10:0]        sys_to_ref_mult,
  // system clock side
  input  wire logic          sys_clk_tick,
  input  wire logic          low_power_halt_instr,
  output logic               chip_reset_n,
  output logic               slow_bus_clock,
  output logic               stop_core_from_vco,
  output logic               stop_vco_off,
  output logic               clock_output_pin_en,
  output logic               irq
);

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [15:0]        ctrl_q, ctrl_d;
  logic               ext_clk_q;
  logic               strap_taken_q;
  logic               written_q;
  logic               ref_lost_q;
  logic               sys_reset_req_q;
  pcs_state_e         state_q, state_d;
  logic [15:0]        relock_cnt_q, relock_cnt_d;
  logic [3:0]         slow_cnt_q;
  logic               slow_clk_q;
  logic [PCS_EV_W-1:0] status_q, mask_q, ev_set;
  logic [31:0]        prdata_q;
  logic               was_locked_q;

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  wire access    = psel & penable;
  wire wr_en     = access & pwrite;
  wire rd_en     = access & ~pwrite;
  wire is_super  = pprot[0];                                    // privileged access
  wire sel_ctrl  = paddr == PCS_ADDR_CTRL;
  wire sel_stat  = paddr == PCS_ADDR_STATUS;
  wire sel_mask  = paddr == PCS_ADDR_MASK;
  wire sel_state = paddr == PCS_ADDR_STATE;
  wire mapped    = sel_ctrl | sel_stat | sel_mask | sel_state;
  wire ctrl_deny = sel_ctrl & ~is_super;
  wire ctrl_wr   = wr_en & sel_ctrl & is_super;
  wire bad_acc   = access & (~mapped | ctrl_deny);

  assign pready  = 1'b1;
  assign pslverr = bad_acc;
  assign prdata  = prdata_q;

  // ---------------------------------------------------------------
  // control fields
  // ---------------------------------------------------------------
  wire       fb_quad  = ctrl_q[PCS_BIT_FBQUAD];
  wire       out_pre  = ctrl_q[PCS_BIT_OUTPRE];
  wire [5:0] modulus  = ctrl_q[PCS_Y_LSB +: PCS_Y_W];
  wire       div_sel  = ctrl_q[PCS_BIT_DIVSEL];
  wire       loss_rst = ctrl_q[PCS_BIT_LOSSRST];
  wire       stop_src = ctrl_q[PCS_BIT_STOPSRC];
  wire       stop_kp  = ctrl_q[PCS_BIT_STOPKEEP];
  wire       loop_on  = ~ext_clk_q;
  // loop-changing write: W or Y differ from what is stored
  wire       loop_chg = ctrl_wr & loop_on &
                        ((pwdata[PCS_BIT_FBQUAD] != fb_quad) |
                         (pwdata[PCS_Y_LSB +: PCS_Y_W] != modulus));

  // writable bits replace, status bits 4:3 read live
  assign ctrl_d = ctrl_wr ? ((pwdata[15:0] & PCS_CTRL_WMASK) | (ctrl_q & ~PCS_CTRL_WMASK)) : ctrl_q;

  // ---------------------------------------------------------------
  // loop settings to the analog side
  // ---------------------------------------------------------------
  assign loop_cfg.fb_quad      = fb_quad & loop_on;
  assign loop_cfg.out_prescale = out_pre & loop_on;
  assign loop_cfg.modulus      = modulus;
  assign loop_cfg.loop_enable  = loop_on & ~(low_power_halt_instr & ~stop_src);
  // vco over system clock: 2 with prescale bypass, else 4
  assign vco_to_sys_ratio = out_pre ? 10'd2 : 10'd4;
  // multiplier of reference: 4*(Y+1)*2^(2W+X), 1 when clock is external
  assign sys_to_ref_mult = loop_on ?
    11'((PCS_BASE_MULT * (int'(modulus) + 1)) << ((fb_quad ? PCS_FB_PRESCALE_LOG2 : 0) + int'(out_pre)))
    : 11'd1;

  // ---------------------------------------------------------------
  // lock sequencing
  // ---------------------------------------------------------------
  wire relock_done = relock_cnt_q == 16'(RELOCK_REF_CYCLES);
  always_comb begin
    state_d      = state_q;
    relock_cnt_d = relock_cnt_q;
    case (state_q)
      PCS_ST_RESET: begin
        if (ext_clk_q && strap_taken_q) state_d = PCS_ST_LOCKED;
        else if (loop_lock_in && strap_taken_q) state_d = PCS_ST_LOCKED;
      end
      PCS_ST_RELOCK: begin
        if (ref_clk_tick && !relock_done) relock_cnt_d = relock_cnt_q + 16'd1;
        if (relock_done && loop_lock_in) state_d = PCS_ST_LOCKED;
      end
      PCS_ST_LOCKED: begin
        if (loop_chg) begin
          state_d      = PCS_ST_RELOCK;
          relock_cnt_d = '0;
        end
      end
      PCS_ST_LIMP: begin
        if (ref_present_in) begin
          state_d      = PCS_ST_RELOCK;
          relock_cnt_d = '0;
        end
      end
      default: state_d = PCS_ST_RESET;
    endcase
    // reference loss with loop in use overrides every state but reset; a loss reset below overrides it
    if (loop_on && !ref_present_in && state_q != PCS_ST_RESET) state_d = PCS_ST_LIMP;
    // loss reset sends the chip back through the wait for lock
    if (loop_on && !ref_present_in && loss_rst && strap_taken_q) begin
      state_d      = PCS_ST_RESET;
      relock_cnt_d = '0;
    end
  end

  // strap capture after release; chip held until lock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_clk_q     <= 1'b0;
      strap_taken_q <= 1'b0;
    end else if (!strap_taken_q) begin
      ext_clk_q     <= ~clock_source_strap;
      strap_taken_q <= 1'b1;
    end
  end

  // core state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q      <= PCS_ST_RESET;
      relock_cnt_q <= '0;
      ctrl_q       <= PCS_CTRL_RESET;
      written_q    <= 1'b0;
    end else begin
      state_q      <= state_d;
      relock_cnt_q <= relock_cnt_d;
      ctrl_q       <= ctrl_d;
      written_q    <= written_q | ctrl_wr;
    end
  end

  // reference loss flag and loss reset request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_lost_q      <= 1'b0;
      sys_reset_req_q <= 1'b0;
    end else begin
      ref_lost_q      <= loop_on & ~ref_present_in & strap_taken_q;
      sys_reset_req_q <= loop_on & ~ref_present_in & loss_rst & strap_taken_q;
    end
  end

  // chip leaves reset only once lock is reached, re-enters on loss reset
  assign chip_reset_n = (state_q != PCS_ST_RESET) & ~sys_reset_req_q;

  // lock flag: true status only after the first write
  wire lock_flag = ext_clk_q | (written_q ? (state_q == PCS_ST_LOCKED) : 1'b0);

  // ---------------------------------------------------------------
  // slow bus clock divider
  // ---------------------------------------------------------------
  wire [3:0] slow_half = div_sel ? 4'(PCS_SLOW_DIV_HI / 2 - 1) : 4'(PCS_SLOW_DIV_LO / 2 - 1);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slow_cnt_q <= '0;
      slow_clk_q <= 1'b0;
    end else if (sys_clk_tick) begin
      slow_cnt_q <= (slow_cnt_q >= slow_half) ? 4'd0 : slow_cnt_q + 4'd1;
      slow_clk_q <= (slow_cnt_q >= slow_half) ? ~slow_clk_q : slow_clk_q;
    end
  end
  assign slow_bus_clock = slow_clk_q;

  // ---------------------------------------------------------------
  // low-power stop routing; limp keeps prescale scaling via loop_cfg
  // ---------------------------------------------------------------
  assign stop_core_from_vco  = low_power_halt_instr & stop_src;
  assign stop_vco_off        = low_power_halt_instr & ~stop_src & loop_on;
  assign clock_output_pin_en = ~low_power_halt_instr | stop_kp;
  // in limp the out_prescale term of loop_cfg still applies

  // ---------------------------------------------------------------
  // events, status and mask; set wins over clear
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) was_locked_q <= 1'b0;
    else          was_locked_q <= state_q == PCS_ST_LOCKED;
  end
  assign ev_set[PCS_EV_LOCK]   = (state_q == PCS_ST_LOCKED) & ~was_locked_q;
  assign ev_set[PCS_EV_UNLOCK] = (state_q != PCS_ST_LOCKED) & was_locked_q;
  assign ev_set[PCS_EV_REFLOS] = loop_on & ~ref_present_in & ~ref_lost_q & strap_taken_q;
  wire [PCS_EV_W-1:0] st_clr = (wr_en & sel_stat) ? pwdata[PCS_EV_W-1:0] : '0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_q <= '0;
      mask_q   <= '0;
    end else begin
      status_q <= (status_q & ~st_clr) | ev_set;
      if (wr_en && sel_mask) mask_q <= pwdata[PCS_EV_W-1:0];
    end
  end
  assign irq = |(status_q & mask_q);

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------
  wire [15:0] ctrl_view = {ctrl_q[15:5], ref_lost_q, lock_flag, ctrl_q[2:0]};
  wire [31:0] rd_mux = (sel_ctrl & is_super) ? {16'h0000, ctrl_view} :
                       sel_stat  ? {29'h0, status_q} :
                       sel_mask  ? {29'h0, mask_q} :
                       sel_state ? {27'h0, ext_clk_q, chip_reset_n, lock_flag, state_q} : 32'h0000_0000;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata_q <= '0;
    else if (psel && !penable && !pwrite) prdata_q <= rd_mux;
  end

endmodule : pcs_clock_synth_ctrl

// ===== bench/pcs_ctrl_assertions.sv
// port checker for the clock synthesizer control block
// assumes one pclk domain; bound to the design from the bench top
`timescale 1ns/100ps
module pcs_ctrl_assertions
  import pcs_pkg::*;
(
  input wire logic          pclk, presetn, psel, penable, pwrite, pslverr,
  input wire logic          loop_lock_in, ref_present_in, low_power_halt_instr,
  input wire logic          chip_reset_n, stop_core_from_vco, stop_vco_off, clock_output_pin_en,
  input wire logic [7:0]    paddr,
  input wire logic [2:0]    pprot,
  input wire logic [31:0]   pwdata, prdata,
  input wire logic [9:0]    vco_to_sys_ratio,
  input wire logic [10:0]   sys_to_ref_mult,
  input wire pcs_loop_cfg_s loop_cfg
);
  // --------------------
  // helper logic
  // --------------------
  logic [15:0] sw_q;  // last supervisor write to ctrl
  wire logic        ctl_wr = psel && penable && pwrite && pprot[0] && paddr == PCS_ADDR_CTRL;
  wire logic [13:0] base_w = {6'h00, loop_cfg.modulus, 2'h0} + 14'h0004;
  wire logic [13:0] mult_w = base_w << {loop_cfg.fb_quad, loop_cfg.out_prescale};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) sw_q <= PCS_CTRL_RESET;
    else if (ctl_wr) sw_q <= pwdata[15:0];
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // --------------------
  // assertions
  // --------------------
  AST_RESET_CTRL: assert property (!$past(presetn) && loop_cfg.loop_enable |-> loop_cfg.modulus == 6'h3F
    && !loop_cfg.fb_quad && !loop_cfg.out_prescale) else $error("ctrl fields not at reset value");
  AST_CHIP_RST: assert property ($rose(chip_reset_n) && loop_cfg.loop_enable |-> $past(loop_lock_in))
    else $error("chip reset released before lock");
  AST_VCO_RATIO: assert property (loop_cfg.loop_enable |->
    vco_to_sys_ratio == (loop_cfg.out_prescale ? 10'h002 : 10'h004)) else $error("vco ratio wrong");
  AST_MULT: assert property (loop_cfg.loop_enable |-> sys_to_ref_mult == mult_w[10:0])
    else $error("multiplier wrong");
  AST_EXT_MULT: assert property (!loop_cfg.loop_enable && !low_power_halt_instr |-> sys_to_ref_mult == 11'h001)
    else $error("external clock multiplier wrong");
  AST_REFUSE: assert property (psel && penable && !pwrite && !pprot[0] && paddr == PCS_ADDR_CTRL
    |-> pslverr && prdata == 32'h0) else $error("user read of ctrl not refused");
  AST_STOP_SRC: assert property (low_power_halt_instr && loop_cfg.loop_enable |->
    stop_core_from_vco == sw_q[PCS_BIT_STOPSRC] && stop_vco_off == !sw_q[PCS_BIT_STOPSRC])
    else $error("stop clock source wrong");
  AST_STOP_PIN: assert property (low_power_halt_instr && !sw_q[PCS_BIT_STOPKEEP] |-> !clock_output_pin_en)
    else $error("clock pin driven in stop");
  AST_LOSS_RST: assert property (loop_cfg.loop_enable && sw_q[PCS_BIT_LOSSRST] && !ref_present_in
    ##1 !ref_present_in |-> !chip_reset_n) else $error("loss of reference did not reset");
  COV_FBQUAD: cover property (ctl_wr && pwdata[PCS_BIT_FBQUAD]);
  COV_STOP: cover property (low_power_halt_instr && clock_output_pin_en);
  COV_LOSS: cover property ($fell(chip_reset_n));
endmodule : pcs_ctrl_assertions

// ===== bench/pcs_ref_model.sv
// reference source and analog loop stand-in for the control block
// assumes loop settings come from the block; reference loss is commanded by the bench
`timescale 1ns/100ps
module pcs_ref_model
  import pcs_pkg::*;
#(
  parameter int REF_DIV    = 4,
  parameter int LOCK_TICKS = 3
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          ref_off,
  input  wire pcs_loop_cfg_s loop_cfg,
  output logic               ref_clk_tick,
  output logic               ref_present_in,
  output logic               loop_lock_in
);
  logic [3:0] div_q, wait_q;
  logic [6:0] set_q;
  wire logic [6:0] set_w = {loop_cfg.fb_quad, loop_cfg.modulus};
  // reference divider and lock timer; a feedback change restarts the wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q  <= 4'h0;
      wait_q <= 4'h0;
      set_q  <= 7'h00;
    end else begin
      div_q <= (div_q == 4'(REF_DIV - 1)) ? 4'h0 : div_q + 4'h1;
      set_q <= set_w;
      if (!loop_cfg.loop_enable || set_q != set_w) wait_q <= 4'h0;
      else if (ref_clk_tick && wait_q != 4'(LOCK_TICKS)) wait_q <= wait_q + 4'h1;
    end
  end
  assign ref_clk_tick   = !ref_off && div_q == 4'h0;
  assign ref_present_in = !ref_off;
  assign loop_lock_in   = !ref_off && wait_q == 4'(LOCK_TICKS);
endmodule : pcs_ref_model

// ===== bench/tb_pcs_clock_synth_ctrl.sv
// self-checking bench for the clock synthesizer control block
// assumes the loop stand-in on the analog side and the port checker bound below
`timescale 1ns/100ps
`define CHK(n, e, a) begin n_tests++; if ((a) !== (e)) begin err_count++; \
  $display("wrong value %s expected %0h seen %0h", n, e, a); end end
module tb_pcs_clock_synth_ctrl;
  import pcs_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, strap = 1;
  logic halt = 0, sys_tick = 0, ref_off = 0, er;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, rd;
  logic [2:0] pprot = 3'h1;
  logic pready, pslverr, lock, refp, rtick, cres_n, slow, sfv, voff, pin, irq;
  logic [31:0] prdata;
  pcs_loop_cfg_s cfg;
  logic [9:0] vr;
  logic [10:0] mult;
  int err_count = 0, n_tests = 0;
  always #25 pclk = ~pclk;
  always @(posedge pclk) sys_tick <= ~sys_tick;  // system clock pulse every second pclk
  pcs_clock_synth_ctrl #(.RELOCK_REF_CYCLES(2)) DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pprot, .pready, .prdata, .pslverr, .clock_source_strap(strap), .loop_lock_in(lock),
    .ref_present_in(refp), .ref_clk_tick(rtick), .loop_cfg(cfg), .vco_to_sys_ratio(vr), .sys_to_ref_mult(mult),
    .sys_clk_tick(sys_tick), .low_power_halt_instr(halt), .chip_reset_n(cres_n), .slow_bus_clock(slow),
    .stop_core_from_vco(sfv), .stop_vco_off(voff), .clock_output_pin_en(pin), .irq);
  pcs_ref_model u_ref (.pclk, .presetn, .ref_off, .loop_cfg(cfg), .ref_clk_tick(rtick),
    .ref_present_in(refp), .loop_lock_in(lock));
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict
  task automatic timeout(input int k, input int n);
    if (k >= n) begin err_count++; give_verdict; end
  endtask : timeout
  // one apb transfer, read data and error taken at the pready edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [2:0] p);
    int k;
    k = 0;
    psel <= 1'h1; pwrite <= w; paddr <= a; pwdata <= d; pprot <= p;
    @(posedge pclk) penable <= 1'h1;
    do begin @(posedge pclk); k++; end while (pready !== 1'h1 && k < 20);
    timeout(k, 20);
    rd = prdata; er = pslverr;
    psel <= 1'h0; penable <= 1'h0;
    @(posedge pclk);
  endtask : apb
  task automatic wait_lock;
    int k;
    k = 0;
    do begin apb(0, PCS_ADDR_CTRL, 0, 3'h1); k++; end while (rd[PCS_BIT_LOCK] !== 1'h1 && k < 40);
    timeout(k, 40);
  endtask : wait_lock
  task automatic do_reset(input logic s);
    int k;
    k = 0;
    presetn <= 1'h0; strap <= s;
    repeat (5) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk) strap <= 1'h1;  // strap only counts at the first pclk edge after reset release
    `CHK("chip reset held", 1'h0, cres_n)
    while (cres_n !== 1'h1 && k < 200) begin @(posedge pclk); k++; end
    timeout(k, 200);
  endtask : do_reset
  task automatic t_reset;
    do_reset(1'h1);
    apb(0, PCS_ADDR_CTRL, 0, 3'h1);
    `CHK("ctrl reset", 32'h3F00, rd)
    `CHK("mult reset", 11'h100, mult)
    apb(1, PCS_ADDR_CTRL, 32'h0100, 3'h0);
    `CHK("user write", 1'h1, er)
    apb(0, PCS_ADDR_CTRL, 0, 3'h0);
    `CHK("user read", 33'h100000000, {er, rd})
    apb(0, PCS_ADDR_CTRL, 0, 3'h1);
    `CHK("ctrl kept", 32'h3F00, rd)
    apb(0, 8'h10, 0, 3'h1);
    `CHK("unmapped", 1'h1, er)
    $display("test reset done");
  endtask : t_reset
  task automatic t_freq;
    logic [15:0] v[3] = '{16'h0500, 16'h4500, 16'hC500};
    logic [10:0] m[3] = '{11'h018, 11'h030, 11'h0C0};
    logic        l[3] = '{1'h0, 1'h1, 1'h0};
    apb(1, PCS_ADDR_MASK, 32'h0, 3'h1);
    for (int i = 0; i < 3; i++) begin
      apb(1, PCS_ADDR_CTRL, {16'h0, v[i]}, 3'h1);
      `CHK("mult", m[i], mult)
      `CHK("vco ratio", v[i][14] ? 10'h002 : 10'h004, vr)
      apb(0, PCS_ADDR_CTRL, 0, 3'h1);
      `CHK("lock after write", l[i], rd[PCS_BIT_LOCK])
      wait_lock;
    end
    @(posedge pclk);
    `CHK("irq masked", 1'h0, irq)
    apb(1, PCS_ADDR_MASK, 32'h2, 3'h1);
    @(posedge pclk);
    `CHK("irq raised", 1'h1, irq)
    apb(1, PCS_ADDR_STATUS, 32'h7, 3'h1);
    apb(0, PCS_ADDR_STATUS, 0, 3'h1);
    `CHK("status cleared", 32'h0, rd)
    `CHK("irq cleared", 1'h0, irq)
    $display("test frequency done");
  endtask : t_freq
  task automatic t_slow;
    int ticks, k, rises;
    logic prv;
    for (int s = 0; s < 2; s++) begin
      apb(1, PCS_ADDR_CTRL, {16'h0, 8'hC5, s[0], 7'h00}, 3'h1);
      ticks = 0; k = 0; rises = 0; prv = slow;
      while (rises < 2 && k < 200) begin
        @(posedge pclk); k++;
        if (rises == 1 && sys_tick) ticks++;
        if (slow === 1'h1 && prv === 1'h0) rises++;
        prv = slow;
      end
      timeout(k, 200);
      `CHK("slow period", s ? 16 : 8, ticks)
    end
    $display("test slow clock done");
  endtask : t_slow
  task automatic t_stop;
    for (int b = 0; b < 4; b++) begin
      apb(1, PCS_ADDR_CTRL, {16'h0, 8'hC5, 6'h00, b[1:0]}, 3'h1);
      halt <= 1'h1;
      repeat (2) @(posedge pclk);
      `CHK("stop clocks", {b[1], !b[1], b[0]}, {sfv, voff, pin})
      halt <= 1'h0;
    end
    $display("test stop done");
  endtask : t_stop
  task automatic t_loss;
    apb(1, PCS_ADDR_CTRL, 32'hC500, 3'h1);
    ref_off <= 1'h1;
    repeat (3) @(posedge pclk);
    apb(0, PCS_ADDR_CTRL, 0, 3'h1);
    `CHK("ref lost flag", 1'h1, rd[PCS_BIT_REFLOST])
    `CHK("limp keeps chip", 1'h1, cres_n)
    `CHK("limp ratio", 10'h002, vr)
    ref_off <= 1'h0;
    apb(1, PCS_ADDR_CTRL, 32'hC504, 3'h1);
    ref_off <= 1'h1;
    repeat (3) @(posedge pclk);
    `CHK("loss reset", 1'h0, cres_n)
    ref_off <= 1'h0;
    $display("test reference loss done");
  endtask : t_loss
  task automatic t_ext;
    do_reset(1'h0);
    apb(1, PCS_ADDR_CTRL, 32'hC500, 3'h1);
    `CHK("ext mult", 11'h001, mult)
    apb(0, PCS_ADDR_CTRL, 0, 3'h1);
    `CHK("ext lock", 1'h1, rd[PCS_BIT_LOCK])
    $display("test external clock done");
  endtask : t_ext
  initial begin
    t_reset; t_freq; t_slow; t_stop; t_loss; t_ext;
    give_verdict;
  end
endmodule : tb_pcs_clock_synth_ctrl
bind pcs_clock_synth_ctrl pcs_ctrl_assertions u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .pslverr,
  .loop_lock_in, .ref_present_in, .low_power_halt_instr, .chip_reset_n, .stop_core_from_vco, .stop_vco_off,
  .clock_output_pin_en, .paddr, .pprot, .pwdata, .prdata, .vco_to_sys_ratio, .sys_to_ref_mult, .loop_cfg);
